/* File: afm_clkmon.sv */
/*
  master clock monitor: halves the sampled external clock and flags its loss.
  assumes the clock pin is already synchronised and far slower than the core clock.
*/
`timescale 1ns/1ps
module afm_clkmon import afm_pkg::*; #(
  parameter int unsigned LOSS_CYC = CLK_LOSS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sampled clock pin
  input wire logic ext_clk,
  // one-cycle pulse per internal master clock period, and loss level
  output logic mclk_tick,
  output logic clock_lost
);
  localparam int unsigned CW = $clog2(LOSS_CYC + 1);
  if (LOSS_CYC < 2) begin : g_bad_loss
    $error("afm_clkmon: LOSS_CYC too small");
  end

  logic ext_d;
  logic half;
  logic [CW-1:0] idle;
  logic next_half;
  logic next_tick;
  logic next_lost;
  logic [CW-1:0] next_idle;

  always_comb begin
    next_half = half;
    next_tick = 1'b0;
    next_idle = idle;
    next_lost = clock_lost;
    if (ext_clk && !ext_d) begin
      next_half = ~half;
      next_tick = half;
      next_idle = '0;
      next_lost = 1'b0;
    end else if (idle >= CW'(LOSS_CYC)) begin
      next_lost = 1'b1;
    end else begin
      next_idle = idle + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_d <= 1'b0;
      half <= 1'b0;
      idle <= '0;
      mclk_tick <= 1'b0;
      clock_lost <= 1'b0;
    end else begin
      ext_d <= ext_clk;
      half <= next_half;
      idle <= next_idle;
      mclk_tick <= next_tick;
      clock_lost <= next_lost;
    end
  end
endmodule : afm_clkmon

/* File: afm_mcu.sv */
/* controller model: drives mute and standby pins, pulls up both flag lines.
   assumes the bench asks for power on or off and may hold mute low. */
`timescale 1ns/1ps
module afm_mcu #(
  parameter int WAIT_CYC = 400
) (
  // clock
  input wire logic clk,
  // bench requests
  input wire logic want_on,
  input wire logic mute_hold,
  // open-drain flag pins
  input wire logic fault_o,
  input wire logic fault_oe_n,
  input wire logic warn_o,
  input wire logic warn_oe_n,
  // pin levels
  output logic mute_n,
  output logic standby_n,
  output logic fault_line,
  output logic warn_line
);
  logic mute = 1'b0;
  logic sby = 1'b0;
  int cnt = 0;
  // released lines read high through the pull-ups
  assign fault_line = fault_oe_n ? 1'b1 : fault_o;
  assign warn_line = warn_oe_n ? 1'b1 : warn_o;
  assign mute_n = mute & ~mute_hold;
  assign standby_n = sby;
  always @(negedge clk) begin
    if (!want_on) begin
      cnt <= 0;
      if (mute) mute <= 1'b0;
      else sby <= 1'b0;
    end else begin
      sby <= 1'b1;
      if (cnt < WAIT_CYC) cnt <= cnt + 1;
      else mute <= 1'b1;
    end
  end
endmodule : afm_mcu

/* File: afm_pkg.sv */
/*
  package for the amplifier fault and mute sequencer: timing constants, states, carrier structs.
  assumes a 200 MHz core clock; the external master clock is sampled as a plain pin.
*/
// Notes on behaviour
// - overcurrent at the peak limit asserts the active-low fault output.
// - every fault is latched until mute goes low then high again.
// - power-stage supply undervoltage puts outputs high-z and latches fault.
// - master clock loss sets the fault and holds it until mute cycles.
// - thermal warning goes low in warning band, releases when cooled.
// - die temperature past shutdown limit stops power stage, latches fault.
// - all fault sources share one fault output and each forces shutdown.
// - mute low keeps the power stage disabled.
// - mute high enables the power stage through a gradual soft turn-on.
// - standby low: modulator stopped, power stage high impedance.
// - after standby high modulator runs while power stage stays high-z.
// - internal mute interval after wake scales with master clock, overrides mute.
// - switching starts after interval plus short delay and mute released.
// - power stage stays off if digital or power-stage supply is absent.
// - fault and thermal warning are open-drain active-low outputs.
// - internal master clock is the external clock input halved.
package afm_pkg;
  localparam int unsigned CORE_MHZ = 200;
  // internal mute interval in master clock periods: 650 ms at 12.288 MHz internal clock
  localparam int unsigned INT_MUTE_MS = 650;
  localparam int unsigned INT_MCLK_KHZ = 12288;
  localparam int unsigned INT_MUTE_TICKS = INT_MUTE_MS * INT_MCLK_KHZ;
  // extra delay in core cycles, derived from 200 us
  localparam int unsigned EXTRA_DELAY_US = 200;
  localparam int unsigned EXTRA_DELAY_CYC = EXTRA_DELAY_US * CORE_MHZ;
  // clock loss: no master clock edge seen for this long
  localparam int unsigned CLK_LOSS_NS = 1000;
  localparam int unsigned CLK_LOSS_CYC = CLK_LOSS_NS * CORE_MHZ / 1000;
  // soft turn-on ramp length in core cycles, from 10 ms
  localparam int unsigned SOFT_ON_US = 10000;
  localparam int unsigned SOFT_ON_CYC = SOFT_ON_US * CORE_MHZ;
  localparam int unsigned RAMP_W = 8;

  typedef enum logic [2:0] {
    AFM_SLEEP = 3'b000,
    AFM_WAKE = 3'b001,
    AFM_EXTRA = 3'b010,
    AFM_MUTED = 3'b011,
    AFM_RAMP = 3'b100,
    AFM_RUN = 3'b101
  } afm_state_e;

  typedef struct packed {
    logic overcurrent;
    logic pstage_uv;
    logic digital_uv;
    logic over_temp;
    logic clock_lost;
  } afm_fault_s;

  typedef struct packed {
    logic modulator_run;
    logic stage_enable;
    logic stage_hiz;
    logic [RAMP_W-1:0] soft_level;
  } afm_stage_s;
endpackage : afm_pkg

/* File: afm_sva.sv */
/* checker for the fault latch, warning flag and power-stage sequencing of afm_top.
   sees only the top ports; bound to every afm_top instance. */
`timescale 1ns/1ps
module afm_sva (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // inputs
  input wire logic MUTE_N,
  input wire logic STANDBY_N,
  input wire logic OVERCURRENT,
  input wire logic POWER_STAGE_SUPPLY_OK,
  input wire logic TEMP_WARN,
  input wire logic TEMP_SHUTDOWN,
  // outputs
  input wire logic FAULT_N_O,
  input wire logic FAULT_N_OE_N,
  input wire logic THERMAL_WARN_N_O,
  input wire logic THERMAL_WARN_N_OE_N,
  input wire logic MODULATOR_RUN,
  input wire logic STAGE_ENABLE,
  input wire logic STAGE_HIZ,
  input wire logic [7:0] SOFT_LEVEL,
  input wire logic INT_MUTE_ACTIVE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // pins pass a synchroniser, so allow up to ten cycles
  oc_fault_a: assert property ($rose(OVERCURRENT) |-> ##[1:10] !FAULT_N_OE_N)
    else $error("overcurrent not flagged");
  uv_fault_a: assert property ($fell(POWER_STAGE_SUPPLY_OK) |-> ##[1:10] (!FAULT_N_OE_N && STAGE_HIZ))
    else $error("undervoltage not flagged");
  hot_fault_a: assert property ($rose(TEMP_SHUTDOWN) |-> ##[1:10] (!FAULT_N_OE_N && !STAGE_ENABLE))
    else $error("overtemperature not flagged");
  fault_hold_a: assert property (MUTE_N [*8] ##0 !FAULT_N_OE_N |=> !FAULT_N_OE_N)
    else $error("fault released without mute cycle");
  fault_stop_a: assert property (!FAULT_N_OE_N |-> ##[0:1] !STAGE_ENABLE)
    else $error("stage runs with fault latched");
  warn_flag_a: assert property (TEMP_WARN [*8] |-> !THERMAL_WARN_N_OE_N)
    else $error("thermal warning not driven");
  mute_off_a: assert property (!MUTE_N [*8] |-> (!STAGE_ENABLE && SOFT_LEVEL == 8'h00))
    else $error("stage on while muted");
  sleep_off_a: assert property (!STANDBY_N [*8] |-> (!MODULATOR_RUN && STAGE_HIZ))
    else $error("active in standby");
  stage_gate_a: assert property (STAGE_ENABLE |-> (MODULATOR_RUN && !INT_MUTE_ACTIVE))
    else $error("stage on during internal mute");
  soft_ramp_a: assert property (STAGE_ENABLE && $past(STAGE_ENABLE) |-> SOFT_LEVEL >= $past(SOFT_LEVEL))
    else $error("soft level fell while on");
  open_drain_a: assert property (FAULT_N_O == 1'b0 && THERMAL_WARN_N_O == 1'b0)
    else $error("open-drain data not low");
endmodule : afm_sva
bind afm_top afm_sva chk_i (.*);

/* File: afm_sync.sv */
/*
  three-flop input synchroniser with agreement filter.
  assumes an asynchronous source; reset is the synchronised core reset.
*/
`timescale 1ns/1ps
module afm_sync import afm_pkg::*; #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and clean level
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  logic next_dout;

  // change counts only when stages two and three agree
  always_comb begin
    next_dout = dout;
    if (s2 == s3) begin
      next_dout = s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      dout <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : afm_sync

/* File: afm_top.sv */
/*
  fault latch, thermal warning and standby/mute power-stage sequencer.
  assumes pin inputs asynchronous to CORE_CLK; analog comparators deliver logic levels.
*/
`timescale 1ns/1ps
module afm_top import afm_pkg::*; #(
  parameter int unsigned INT_TICKS = INT_MUTE_TICKS,
  parameter int unsigned EXTRA_CYC = EXTRA_DELAY_CYC,
  parameter int unsigned SOFT_CYC = SOFT_ON_CYC,
  parameter int unsigned LOSS_CYC = CLK_LOSS_CYC
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // external master clock pin
  input wire logic EXT_CLK,
  // controller inputs
  input wire logic MUTE_N,
  input wire logic STANDBY_N,
  // analog monitor levels
  input wire logic OVERCURRENT,
  input wire logic POWER_STAGE_SUPPLY_OK,
  input wire logic DIGITAL_SUPPLY_OK,
  input wire logic TEMP_WARN,
  input wire logic TEMP_SHUTDOWN,
  // open-drain flags, enable low while driving low
  output logic FAULT_N_O,
  output logic FAULT_N_OE_N,
  output logic THERMAL_WARN_N_O,
  output logic THERMAL_WARN_N_OE_N,
  // power stage control
  output logic MODULATOR_RUN,
  output logic STAGE_ENABLE,
  output logic STAGE_HIZ,
  output logic [RAMP_W-1:0] SOFT_LEVEL,
  // status
  output logic INT_MUTE_ACTIVE
);
  localparam int unsigned TW = $clog2(INT_TICKS + 1);
  localparam int unsigned EW = $clog2(EXTRA_CYC + 1);
  localparam int unsigned SW = $clog2(SOFT_CYC / (2 ** RAMP_W) + 2);
  localparam int unsigned STEP_CYC = SOFT_CYC / (2 ** RAMP_W);
  // positions of the pins inside the synchroniser bank
  localparam int unsigned PIN_COUNT = 7;
  localparam int unsigned PIN_EXT_CLK = 6;
  localparam int unsigned PIN_MUTE = 5;
  localparam int unsigned PIN_STANDBY = 4;
  localparam int unsigned PIN_OVERCURRENT = 3;
  localparam int unsigned PIN_PSTAGE_UV = 2;
  localparam int unsigned PIN_DIGITAL_UV = 1;
  localparam int unsigned PIN_OVER_TEMP = 0;

  // refuse timings that the counters cannot serve
  if (INT_TICKS < 1) begin : g_bad_ticks
    $error("afm_top: INT_TICKS must be at least one");
  end
  if (EXTRA_CYC < 1) begin : g_bad_extra
    $error("afm_top: EXTRA_CYC must be at least one");
  end
  // a shorter ramp would have to skip levels, which defeats the soft turn-on
  if (STEP_CYC < 1) begin : g_bad_step
    $error("afm_top: SOFT_CYC must give every ramp level one cycle");
  end
  if (LOSS_CYC < 2) begin : g_bad_loss
    $error("afm_top: LOSS_CYC too small");
  end

  // reset release through two flops
  logic rst_a;
  logic rst_n;
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  // input synchronisers
  logic ext_clk_s;
  logic mute_n_s;
  logic standby_n_s;
  afm_fault_s raw;
  logic warn_s;
  logic [PIN_COUNT-1:0] pin_vec;
  logic [PIN_COUNT-1:0] pin_sync;
  // supplies become undervoltage levels, so every fault bit of the bank is active high
  always_comb begin
    pin_vec = '0;
    pin_vec[PIN_EXT_CLK] = EXT_CLK;
    pin_vec[PIN_MUTE] = MUTE_N;
    pin_vec[PIN_STANDBY] = STANDBY_N;
    pin_vec[PIN_OVERCURRENT] = OVERCURRENT;
    pin_vec[PIN_PSTAGE_UV] = ~POWER_STAGE_SUPPLY_OK;
    pin_vec[PIN_DIGITAL_UV] = ~DIGITAL_SUPPLY_OK;
    pin_vec[PIN_OVER_TEMP] = TEMP_SHUTDOWN;
  end

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
    afm_sync #(.INIT(1'b0)) u_sync (
      .clk(CORE_CLK),
      .rst_n(rst_n),
      .din(pin_vec[i]),
      .dout(pin_sync[i])
    );
  end
  afm_sync #(.INIT(1'b0)) u_warn_sync (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .din(TEMP_WARN),
    .dout(warn_s)
  );

  assign ext_clk_s = pin_sync[PIN_EXT_CLK];
  assign mute_n_s = pin_sync[PIN_MUTE];
  assign standby_n_s = pin_sync[PIN_STANDBY];

  logic mclk_tick;
  logic clock_lost;
  afm_clkmon #(.LOSS_CYC(LOSS_CYC)) u_clkmon (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .ext_clk(ext_clk_s),
    .mclk_tick(mclk_tick),
    .clock_lost(clock_lost)
  );

  // combined fault sources
  always_comb begin
    raw.overcurrent = pin_sync[PIN_OVERCURRENT];
    raw.pstage_uv = pin_sync[PIN_PSTAGE_UV];
    raw.digital_uv = pin_sync[PIN_DIGITAL_UV];
    raw.over_temp = pin_sync[PIN_OVER_TEMP];
    raw.clock_lost = clock_lost;
  end

  // fault latch and mute edge detection
  logic fault_latched;
  logic mute_prev;
  logic next_fault;
  logic mute_rise;
  // mute_prev resets to the muted level, so no false rising edge follows reset
  assign mute_rise = mute_n_s && !mute_prev;

  // a persisting fault wins over the clear, so the latch sets again at once
  always_comb begin
    next_fault = fault_latched;
    if (mute_rise) begin
      next_fault = 1'b0;
    end
    if (|raw) begin
      next_fault = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      fault_latched <= 1'b0;
      mute_prev <= 1'b0;
    end else begin
      fault_latched <= next_fault;
      mute_prev <= mute_n_s;
    end
  end

  // supplies are checked live as well, not only through the latch
  logic stage_block;
  assign stage_block = next_fault || raw.pstage_uv || raw.digital_uv;

  // the stage switches in these two states only; decoded for the outputs and the overrides
  function automatic logic is_switching(input afm_state_e s);
    return (s == AFM_RAMP) || (s == AFM_RUN);
  endfunction : is_switching

  // sequencer
  afm_state_e state;
  afm_state_e next_state;
  logic [TW-1:0] tick_cnt;
  logic [TW-1:0] next_tick_cnt;
  logic [EW-1:0] extra_cnt;
  logic [EW-1:0] next_extra_cnt;
  logic [SW-1:0] step_cnt;
  logic [SW-1:0] next_step_cnt;
  logic [RAMP_W-1:0] level;
  logic [RAMP_W-1:0] next_level;

  always_comb begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_extra_cnt = extra_cnt;
    next_step_cnt = step_cnt;
    next_level = level;
    case (state)
      AFM_SLEEP: begin
        next_tick_cnt = '0;
        next_extra_cnt = '0;
        next_level = '0;
        if (standby_n_s) begin
          next_state = AFM_WAKE;
        end
      end
      AFM_WAKE: begin
        // interval counted in master clock periods, so it scales with that clock
        // a stopped master clock stalls it here, while the clock-loss fault is raised
        if (mclk_tick) begin
          next_tick_cnt = tick_cnt + TW'(1);
        end
        if (tick_cnt >= TW'(INT_TICKS)) begin
          next_state = AFM_EXTRA;
        end
      end
      AFM_EXTRA: begin
        next_extra_cnt = extra_cnt + EW'(1);
        if (extra_cnt >= EW'(EXTRA_CYC - 1)) begin
          next_state = AFM_MUTED;
        end
      end
      AFM_MUTED: begin
        next_level = '0;
        next_step_cnt = '0;
        if (mute_n_s && !stage_block) begin
          next_state = AFM_RAMP;
        end
      end
      AFM_RAMP: begin
        next_step_cnt = step_cnt + SW'(1);
        if (step_cnt >= SW'(STEP_CYC - 1)) begin
          next_step_cnt = '0;
          next_level = level + RAMP_W'(1);
          if (&level) begin
            next_level = level;
            next_state = AFM_RUN;
          end
        end
      end
      AFM_RUN: begin
        next_state = AFM_RUN;
      end
      default: begin
        next_state = AFM_SLEEP;
      end
    endcase
    // standby override applies in every awake state; mute and fault overrides apply only in AFM_RAMP and AFM_RUN
    if (!standby_n_s) begin
      next_state = AFM_SLEEP;
      next_level = '0;
      next_step_cnt = '0;
    end else if (is_switching(state) && (!mute_n_s || stage_block)) begin
      next_state = AFM_MUTED;
      next_level = '0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= AFM_SLEEP;
      tick_cnt <= '0;
      extra_cnt <= '0;
      step_cnt <= '0;
      level <= '0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      extra_cnt <= next_extra_cnt;
      step_cnt <= next_step_cnt;
      level <= next_level;
    end
  end

  // registered outputs
  afm_stage_s stage;
  always_comb begin
    stage.modulator_run = (next_state != AFM_SLEEP);
    stage.stage_enable = is_switching(next_state);
    stage.stage_hiz = !stage.stage_enable;
    stage.soft_level = next_level;
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      FAULT_N_O <= 1'b0;
      FAULT_N_OE_N <= 1'b1;
      THERMAL_WARN_N_O <= 1'b0;
      THERMAL_WARN_N_OE_N <= 1'b1;
      MODULATOR_RUN <= 1'b0;
      STAGE_ENABLE <= 1'b0;
      STAGE_HIZ <= 1'b1;
      SOFT_LEVEL <= '0;
      INT_MUTE_ACTIVE <= 1'b0;
    end else begin
      // data pins stay low and only the enables move, so several flags can share one line
      FAULT_N_O <= 1'b0;
      FAULT_N_OE_N <= !next_fault;
      THERMAL_WARN_N_O <= 1'b0;
      THERMAL_WARN_N_OE_N <= !warn_s;
      MODULATOR_RUN <= stage.modulator_run;
      STAGE_ENABLE <= stage.stage_enable;
      STAGE_HIZ <= stage.stage_hiz;
      SOFT_LEVEL <= stage.soft_level;
      INT_MUTE_ACTIVE <= (next_state == AFM_WAKE) || (next_state == AFM_EXTRA);
    end
  end
endmodule : afm_top

/* File: testbench.sv */
/* self-checking bench for afm_top with shortened counts.
   assumes the controller model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module testbench;
  localparam int IT = 20;
  localparam int EX = 4;
  localparam int EP = 8;
  logic core_clk = 0, nrst = 0, ext_clk = 0, want_on = 0, mute_hold = 0, temp_warn = 0;
  logic [4:0] flt = 5'h00;
  logic mute_n, standby_n, fault_line, warn_line, f_o, f_oe, w_o, w_oe;
  logic mod_run, st_en, st_hiz, int_mute;
  logic [7:0] lvl;
  int bad_count = 0, tests_run = 0, cyc_cnt = 0, n;
  always #2.5 core_clk = ~core_clk;
  // the master clock stops while a clock-loss fault is wanted
  always @(negedge core_clk) begin
    cyc_cnt++;
    if (!flt[4] && cyc_cnt % (EP / 2) == 0) ext_clk <= ~ext_clk;
    if (cyc_cnt > 20000) begin
      bad_count++;
      final_report();
    end
  end
  afm_top #(.INT_TICKS(IT), .EXTRA_CYC(EX), .SOFT_CYC(512), .LOSS_CYC(20)) dut (
    .CORE_CLK(core_clk), .NRST(nrst), .EXT_CLK(ext_clk), .MUTE_N(mute_n), .STANDBY_N(standby_n),
    .OVERCURRENT(flt[0]), .POWER_STAGE_SUPPLY_OK(!flt[1]), .DIGITAL_SUPPLY_OK(!flt[2]),
    .TEMP_WARN(temp_warn), .TEMP_SHUTDOWN(flt[3]), .FAULT_N_O(f_o), .FAULT_N_OE_N(f_oe),
    .THERMAL_WARN_N_O(w_o), .THERMAL_WARN_N_OE_N(w_oe), .MODULATOR_RUN(mod_run),
    .STAGE_ENABLE(st_en), .STAGE_HIZ(st_hiz), .SOFT_LEVEL(lvl), .INT_MUTE_ACTIVE(int_mute));
  // short wait on purpose: mute rises well inside the internal interval
  afm_mcu #(.WAIT_CYC(30)) mcu (.clk(core_clk), .want_on(want_on), .mute_hold(mute_hold),
    .fault_o(f_o), .fault_oe_n(f_oe), .warn_o(w_o), .warn_oe_n(w_oe), .mute_n(mute_n),
    .standby_n(standby_n), .fault_line(fault_line), .warn_line(warn_line));
  task cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task toggle_mute;
    mute_hold = 1;
    cyc(10);
    mute_hold = 0;
    cyc(20);
  endtask : toggle_mute
  task wait_ramp;
    n = 0;
    while (lvl !== 8'hff && n < 2000) begin
      cyc(1);
      n++;
    end
  endtask : wait_ramp
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    cyc(12);
    nrst = 1;
    cyc(8);
    chk("modulator", 0, mod_run);
    chk("stage hiz", 1, st_hiz);
    // non-blocking, so the controller model always takes the request one falling edge later
    want_on <= 1;
    n = 0;
    while (int_mute !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk("modulator", 1, mod_run);
    n = 0;
    while (int_mute === 1'b1 && n < 1000) begin
      chk("stage hiz", 1, st_hiz);
      cyc(1);
      n++;
    end
    chk("interval", 1, n >= 2 * IT * EP + EX - 12 && n <= 2 * IT * EP + EX + 12);
    cyc(3);
    chk("stage on", 1, st_en);
    chk("ramp start", 1, lvl < 8'h10);
    wait_ramp;
    chk("soft level", 8'hff, lvl);
    temp_warn = 1;
    cyc(10);
    chk("warn line", 0, warn_line);
    temp_warn = 0;
    cyc(10);
    chk("warn line", 1, warn_line);
    for (int k = 0; k < 5; k++) begin
      flt = 5'h01 << k;
      cyc(40);
      chk("fault line", 0, fault_line);
      chk("stage hiz", 1, st_hiz);
      toggle_mute;
      chk("fault held", 0, fault_line);
      flt = 5'h00;
      cyc(40);
      chk("fault held", 0, fault_line);
      toggle_mute;
      chk("fault clear", 1, fault_line);
      wait_ramp;
      chk("stage back", 1, st_en);
    end
    mute_hold = 1;
    cyc(10);
    chk("muted stage", 0, st_en);
    chk("muted level", 0, lvl);
    mute_hold = 0;
    wait_ramp;
    want_on <= 0;
    cyc(15);
    chk("modulator", 0, mod_run);
    chk("stage hiz", 1, st_hiz);
    final_report();
  end
endmodule : testbench
